/* lpc_defs.vh */
// constants for the line port clock select block
// assumes inclusion by bare name from every design file of the block
`ifndef LPC_DEFS_VH
`define LPC_DEFS_VH

// register map, 7-bit register address
`define LPC_ADDR_W 7
`define LPC_DATA_W 8
`define LPC_CLKCFG_ADDR 7'h01
`define LPC_CLKCFG_RESET 8'h00
// transmit timing source field, bits 4:3
`define LPC_SRC_LSB 3
`define LPC_SRC_MSB 4
// source encodings
`define LPC_SRC_SYNTH 2'h0
`define LPC_SRC_FRAME 2'h1
`define LPC_SRC_LOOP 2'h2
`define LPC_SRC_EXT 2'h3

// timing, system clock period in ns
`define LPC_CLK_PERIOD_NS 8
// reference considered lost after this long without an edge (least time)
`define LPC_REF_TIMEOUT_NS 1000
`define LPC_REF_TIMEOUT_CYC \
    ((`LPC_REF_TIMEOUT_NS + `LPC_CLK_PERIOD_NS - 1) / `LPC_CLK_PERIOD_NS)
// half period of the synthesized transmit clock (longest time)
`define LPC_SYNTH_HALF_NS 32
`define LPC_SYNTH_HALF_CYC (`LPC_SYNTH_HALF_NS / `LPC_CLK_PERIOD_NS)
`define LPC_CNT_W 8

// buffer word width
`define LPC_BUF_W 1

`endif

/* lpc_buf2.v */
// two-entry valid/ready buffer for serial line bits
// assumes both sides on sys_clk, rstn asynchronous active low
`timescale 1ns/1ns
`default_nettype none
`include "lpc_defs.vh"

module lpc_buf2 (
    input wire sys_clk,
    input wire rstn,
    input wire [`LPC_BUF_W-1:0] in_data,
    input wire in_valid,
    output wire in_ready,
    output reg [`LPC_BUF_W-1:0] out_data,
    output wire out_valid,
    input wire out_ready
);

    // ****************************************
    // storage and pointers
    // ****************************************
    reg [`LPC_BUF_W-1:0] mem_reg [0:1]; // two entries
    reg wr_ptr_reg; // next slot to fill
    reg rd_ptr_reg; // next slot to drain
    reg [1:0] count_reg; // 0, 1 or 2 entries held
    wire push;
    wire pop;

    assign in_ready = (count_reg != 2'h2);
    assign out_valid = (count_reg != 2'h0);
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // output word taken from the read slot
    always @* begin
        out_data = mem_reg[rd_ptr_reg];
    end

    // ****************************************
    // fill, drain and count
    // ****************************************
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            mem_reg[0] <= {`LPC_BUF_W{1'b0}};
            mem_reg[1] <= {`LPC_BUF_W{1'b0}};
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg <= 2'h0;
        end else begin
            if (push) begin
                // write into the free slot
                mem_reg[wr_ptr_reg] <= in_data;
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (pop) begin
                // advance past the drained slot
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            if (push & ~pop) begin
                count_reg <= count_reg + 2'h1;
            end else if (pop & ~push) begin
                count_reg <= count_reg - 2'h1;
            end
        end
    end

endmodule
`default_nettype wire

/* lpc_line_port.v */
// line port and transmit clock source select of one channel
// assumes line pins arrive unsynchronised, registers on sys_clk
//
// Contract
// - tx clock from one of four sources
// - field zero: synthesize from 19.44 MHz reference
// - 19.44 MHz reference feeds both loops always
// - send framed bits as differential NRZ
// - media sends NRZ data with receive clock
// - external source passes tx clock straight through
`timescale 1ns/1ns
`default_nettype none
`include "lpc_defs.vh"

module lpc_line_port (
    input wire sys_clk,
    input wire rstn,
    // register access
    input wire reg_cs,
    input wire reg_we,
    input wire [`LPC_ADDR_W-1:0] reg_addr,
    input wire [`LPC_DATA_W-1:0] reg_wdata,
    output reg [`LPC_DATA_W-1:0] reg_rdata,
    // reference clocks
    input wire synth_reference_clock,
    input wire frame_rate_reference,
    input wire external_tx_clock_in_p,
    input wire external_tx_clock_in_n,
    // transmit line
    output wire line_tx_clock_out_p,
    output wire line_tx_clock_out_n,
    output wire line_tx_serial_out_p,
    output wire line_tx_serial_out_n,
    // receive line
    input wire line_rx_clock_in_p,
    input wire line_rx_clock_in_n,
    input wire line_rx_serial_in_p,
    input wire line_rx_serial_in_n,
    input wire line_signal_present,
    // user side transmit stream
    input wire tx_bit,
    input wire tx_valid,
    output wire tx_ready,
    // user side receive stream
    output wire rx_bit,
    output wire rx_valid,
    input wire rx_ready,
    // status levels and overrun pulse
    output wire ref_active,
    output wire signal_present,
    output reg rx_overrun
);

    // ****************************************
    // differential decode
    // ****************************************
    // a pair with both legs equal keeps the last level
    function diff_level;
        input p;
        input n;
        input last;
        begin
            if (p != n) begin
                diff_level = p;
            end else begin
                diff_level = last;
            end
        end
    endfunction

    // ****************************************
    // input synchronisers
    // ****************************************
    // bit order: 0 ref, 1 frame, 2 ext p, 3 ext n, 4 rxclk p,
    // 5 rxclk n, 6 rxdata p, 7 rxdata n, 8 signal present
    localparam NSYNC = 9;
    wire [NSYNC-1:0] raw_in;
    reg [NSYNC-1:0] meta_reg; // first stage, read only by second
    reg [NSYNC-1:0] sync_reg; // second stage, safe to use

    assign raw_in = {line_signal_present,
                     line_rx_serial_in_n, line_rx_serial_in_p,
                     line_rx_clock_in_n, line_rx_clock_in_p,
                     external_tx_clock_in_n, external_tx_clock_in_p,
                     frame_rate_reference, synth_reference_clock};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
            // two flops per pin
            always @(posedge sys_clk or negedge rstn) begin
                if (!rstn) begin
                    meta_reg[gi] <= 1'b0;
                    sync_reg[gi] <= 1'b0;
                end else begin
                    meta_reg[gi] <= raw_in[gi];
                    sync_reg[gi] <= meta_reg[gi];
                end
            end
        end
    endgenerate

    // ****************************************
    // decoded levels and edge history
    // ****************************************
    reg ref_d_reg; // last reference level
    reg frame_d_reg; // last frame reference level
    reg ext_lvl_reg; // decoded external clock
    reg rxclk_lvl_reg; // decoded receive clock
    reg rxclk_d_reg; // receive clock one cycle back
    reg rxdat_lvl_reg; // decoded receive data
    wire ref_edge;
    wire frame_rise;
    wire rxclk_rise;

    assign ref_edge = sync_reg[0] ^ ref_d_reg;
    assign frame_rise = sync_reg[1] & ~frame_d_reg;
    assign rxclk_rise = rxclk_lvl_reg & ~rxclk_d_reg;
    assign signal_present = sync_reg[8];

    // pair decode and history
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ref_d_reg <= 1'b0;
            frame_d_reg <= 1'b0;
            ext_lvl_reg <= 1'b0;
            rxclk_lvl_reg <= 1'b0;
            rxclk_d_reg <= 1'b0;
            rxdat_lvl_reg <= 1'b0;
        end else begin
            ref_d_reg <= sync_reg[0];
            frame_d_reg <= sync_reg[1];
            ext_lvl_reg <= diff_level(sync_reg[2], sync_reg[3], ext_lvl_reg);
            rxclk_lvl_reg <= diff_level(sync_reg[4], sync_reg[5],
                                        rxclk_lvl_reg);
            rxclk_d_reg <= rxclk_lvl_reg;
            rxdat_lvl_reg <= diff_level(sync_reg[6], sync_reg[7],
                                        rxdat_lvl_reg);
        end
    end

    // ****************************************
    // clock configuration register
    // ****************************************
    reg [`LPC_DATA_W-1:0] clock_source_config_reg;
    wire [1:0] src_sel;

    assign src_sel = clock_source_config_reg[`LPC_SRC_MSB:`LPC_SRC_LSB];

    // write port, read data registered one cycle after request
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            clock_source_config_reg <= `LPC_CLKCFG_RESET;
            reg_rdata <= {`LPC_DATA_W{1'b0}};
        end else begin
            if (reg_cs && reg_we && reg_addr == `LPC_CLKCFG_ADDR) begin
                clock_source_config_reg <= reg_wdata;
            end
            if (reg_cs && !reg_we) begin
                if (reg_addr == `LPC_CLKCFG_ADDR) begin
                    reg_rdata <= clock_source_config_reg;
                end else begin
                    // unmapped address reads zero
                    reg_rdata <= {`LPC_DATA_W{1'b0}};
                end
            end
        end
    end

    // ****************************************
    // reference activity watch
    // ****************************************
    // both loops lean on this reference whatever the selection
    reg [`LPC_CNT_W-1:0] ref_cnt_reg; // cycles since last edge
    reg ref_active_reg;

    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ref_cnt_reg <= {`LPC_CNT_W{1'b0}};
            ref_active_reg <= 1'b0;
        end else if (ref_edge) begin
            ref_cnt_reg <= {`LPC_CNT_W{1'b0}};
            ref_active_reg <= 1'b1;
        end else if (ref_cnt_reg == `LPC_REF_TIMEOUT_CYC - 1) begin
            ref_active_reg <= 1'b0;
        end else begin
            ref_cnt_reg <= ref_cnt_reg + 8'h01;
        end
    end

    assign ref_active = ref_active_reg;

    // ****************************************
    // transmit synthesizer
    // ****************************************
    reg [`LPC_CNT_W-1:0] syn_cnt_reg; // half period counter
    reg syn_clk_reg; // synthesized clock level

    // runs only with a live reference; frame source realigns phase
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            syn_cnt_reg <= {`LPC_CNT_W{1'b0}};
            syn_clk_reg <= 1'b0;
        end else if (!ref_active_reg) begin
            syn_cnt_reg <= {`LPC_CNT_W{1'b0}};
            syn_clk_reg <= 1'b0;
        end else if (src_sel == `LPC_SRC_FRAME && frame_rise) begin
            syn_cnt_reg <= {`LPC_CNT_W{1'b0}};
            syn_clk_reg <= 1'b0;
        end else if (syn_cnt_reg == `LPC_SYNTH_HALF_CYC - 1) begin
            syn_cnt_reg <= {`LPC_CNT_W{1'b0}};
            syn_clk_reg <= ~syn_clk_reg;
        end else begin
            syn_cnt_reg <= syn_cnt_reg + 8'h01;
        end
    end

    // ****************************************
    // source select and transmit clock
    // ****************************************
    reg tx_clk_next;
    reg tx_clk_reg;

    // pick the timing source from the two-bit field
    always @* begin
        case (src_sel)
            `LPC_SRC_SYNTH: tx_clk_next = syn_clk_reg;
            `LPC_SRC_FRAME: tx_clk_next = syn_clk_reg;
            `LPC_SRC_LOOP: tx_clk_next = rxclk_lvl_reg;
            `LPC_SRC_EXT: tx_clk_next = ext_lvl_reg;
            default: tx_clk_next = 1'b0;
        endcase
    end

    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            tx_clk_reg <= 1'b0;
        end else begin
            tx_clk_reg <= tx_clk_next;
        end
    end

    assign line_tx_clock_out_p = tx_clk_reg;
    assign line_tx_clock_out_n = ~tx_clk_reg;

    // ****************************************
    // transmit serial path
    // ****************************************
    wire tx_rise;
    wire txb_bit;
    wire txb_valid;
    reg tx_data_reg; // line bit, changes on tx clock rise

    assign tx_rise = tx_clk_next & ~tx_clk_reg;

    // user bits wait here until the line takes them
    lpc_buf2 u_tx_buf (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .in_data(tx_bit),
        .in_valid(tx_valid),
        .in_ready(tx_ready),
        .out_data(txb_bit),
        .out_valid(txb_valid),
        .out_ready(tx_rise)
    );

    // idle line sends zero when nothing is queued
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            tx_data_reg <= 1'b0;
        end else if (tx_rise) begin
            tx_data_reg <= txb_valid & txb_bit;
        end
    end

    assign line_tx_serial_out_p = tx_data_reg;
    assign line_tx_serial_out_n = ~tx_data_reg;

    // ****************************************
    // receive serial path
    // ****************************************
    wire rx_push;
    wire rxb_ready;

    // capture on receive clock rise while the line carries signal and the reference is active
    assign rx_push = rxclk_rise & signal_present & ref_active_reg;

    lpc_buf2 u_rx_buf (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .in_data(rxdat_lvl_reg),
        .in_valid(rx_push),
        .in_ready(rxb_ready),
        .out_data(rx_bit),
        .out_valid(rx_valid),
        .out_ready(rx_ready)
    );

    // one-cycle pulse when a captured bit finds the buffer full
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rx_overrun <= 1'b0;
        end else begin
            rx_overrun <= rx_push & ~rxb_ready;
        end
    end

endmodule
`default_nettype wire

/* lpc_line_port_properties.sv */
// checker for the line port clock select block
// assumes binding into lpc_line_port, one sys_clk domain
`timescale 1ns/1ns
`default_nettype none
module lpc_props (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic reg_cs,
    input wire logic reg_we,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic synth_reference_clock,
    input wire logic external_tx_clock_in_p,
    input wire logic line_rx_clock_in_p,
    input wire logic line_tx_clock_out_p,
    input wire logic line_tx_clock_out_n,
    input wire logic line_tx_serial_out_p,
    input wire logic line_tx_serial_out_n,
    input wire logic ref_active,
    input wire logic rx_valid,
    input wire logic rx_ready,
    input wire logic rx_bit
);
// ****
// shadow state
// ****
reg [7:0] cfg_reg; // last config written
reg [7:0] mode_reg; // cycles since config write
reg [7:0] quiet_reg; // cycles since reference edge
reg ref_reg; // reference level last edge
wire [1:0] src = cfg_reg[4:3]; // selected source
// track writes and reference activity
always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
        cfg_reg <= 8'h00;
        mode_reg <= 8'h00;
        quiet_reg <= 8'h00;
        ref_reg <= 1'b0;
    end else begin
        ref_reg <= synth_reference_clock;
        if (reg_cs && reg_we && reg_addr == 7'h01) begin
            cfg_reg <= reg_wdata;
            mode_reg <= 8'h00;
        end else if (mode_reg != 8'hff) begin
            mode_reg <= mode_reg + 8'h01;
        end
        if (ref_reg != synth_reference_clock) begin
            quiet_reg <= 8'h00;
        end else if (quiet_reg != 8'hff) begin
            quiet_reg <= quiet_reg + 8'h01;
        end
    end
end
// ****
// properties
// ****
default clocking @(posedge sys_clk); endclocking
default disable iff (!rstn);
clk_legs_a: assert property (
    line_tx_clock_out_n == !line_tx_clock_out_p)
    else $error("tx clock legs equal");
data_legs_a: assert property (
    line_tx_serial_out_n == !line_tx_serial_out_p)
    else $error("tx data legs equal");
read_config_a: assert property (
    reg_cs && !reg_we && reg_addr == 7'h01
    |=> reg_rdata == $past(cfg_reg)) else $error("config read wrong");
read_unmapped_a: assert property (
    reg_cs && !reg_we && reg_addr != 7'h01
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
ext_pass_a: assert property (src == 2'h3 && mode_reg > 8'h08
    |-> line_tx_clock_out_p == $past(external_tx_clock_in_p, 4))
    else $error("external clock not passed");
loop_pass_a: assert property (src == 2'h2 && mode_reg > 8'h08
    |-> line_tx_clock_out_p == $past(line_rx_clock_in_p, 4))
    else $error("receive clock not passed");
synth_half_a: assert property (src == 2'h0 && mode_reg > 8'h10
    && quiet_reg < 8'h40 && ref_active && $rose(line_tx_clock_out_p)
    |-> line_tx_clock_out_p[*4] ##1 !line_tx_clock_out_p)
    else $error("synth half period wrong");
ref_lost_a: assert property (quiet_reg > 8'h88 |-> !ref_active)
    else $error("reference still active");
rx_hold_a: assert property (rx_valid && !rx_ready
    |=> rx_valid && $stable(rx_bit)) else $error("rx word not held");
endmodule
bind lpc_line_port lpc_props u_props (.sys_clk, .rstn, .reg_cs, .reg_we,
    .reg_addr, .reg_wdata, .reg_rdata, .synth_reference_clock,
    .external_tx_clock_in_p, .line_rx_clock_in_p, .line_tx_clock_out_p,
    .line_tx_clock_out_n, .line_tx_serial_out_p, .line_tx_serial_out_n,
    .ref_active, .rx_valid, .rx_ready, .rx_bit);
`default_nettype wire

/* lpc_media_model.sv */
// media module model: receive clock, data and signal present
// assumes tb_top drives run and present; clock idles low
`timescale 1ns/1ns
`default_nettype none
module lpc_media_model (
    input wire logic run,
    input wire logic present,
    input wire logic [15:0] word,
    output logic clk_p,
    output logic clk_n,
    output logic data_p,
    output logic data_n,
    output logic sig_present
);
integer idx = 15; // next bit, msb first
assign clk_n = ~clk_p;
assign data_n = ~data_p;
assign sig_present = run & present;
// one bit per 80 ns, launched while the clock is low
initial begin
    clk_p = 1'b0;
    data_p = 1'b0;
    #3;
    forever begin
        if (run) begin
            data_p = word[idx];
            idx = (idx == 0) ? 15 : idx - 1;
            #40 clk_p = 1'b1;
            #40 clk_p = 1'b0;
        end else begin
            data_p = ~data_p; // released line wanders
            #40;
        end
    end
end
endmodule
`default_nettype wire

/* tb_top.sv */
// testbench for the line port clock select block
// assumes lpc_line_port, lpc_props and lpc_media_model compiled
`timescale 1ns/1ns
`default_nettype none
module tb_top;
// ****
// signals and clocks
// ****
logic sys_clk = 1'b0, rstn = 1'b0, reg_cs = 1'b0, reg_we = 1'b0;
logic [6:0] reg_addr = 7'h00;
logic [7:0] reg_wdata = 8'h00, rd;
logic ref_clk = 1'b0, ref_en = 1'b1, frm = 1'b0, ext = 1'b0, lt;
logic tx_bit = 1'b0, tx_valid = 1'b0, rx_ready = 1'b0;
logic run = 1'b0, present = 1'b0;
wire [7:0] reg_rdata;
wire rc_p, rc_n, rd_p, rd_n, sig, tc_p, tc_n, ts_p, ts_n;
wire tx_ready, rx_bit, rx_valid, ref_active, sig_sync, ovr;
integer num_errors = 0, check_count = 0, k, n, i;
logic [31:0] got;
logic txq[$]; // tx bits seen at clock rises
always #4 sys_clk = ~sys_clk;
initial begin #1; forever #26 if (ref_en) ref_clk = ~ref_clk; end
initial begin #1; forever #1000 frm = ~frm; end
initial begin #1; forever #40 ext = ~ext; end
always @(posedge tc_p) #1 txq.push_back(ts_p);
lpc_line_port DUT (.sys_clk, .rstn, .reg_cs, .reg_we, .reg_addr,
    .reg_wdata, .reg_rdata, .synth_reference_clock(ref_clk),
    .frame_rate_reference(frm), .external_tx_clock_in_p(ext),
    .external_tx_clock_in_n(~ext), .line_tx_clock_out_p(tc_p),
    .line_tx_clock_out_n(tc_n), .line_tx_serial_out_p(ts_p),
    .line_tx_serial_out_n(ts_n), .line_rx_clock_in_p(rc_p),
    .line_rx_clock_in_n(rc_n), .line_rx_serial_in_p(rd_p),
    .line_rx_serial_in_n(rd_n), .line_signal_present(sig), .tx_bit,
    .tx_valid, .tx_ready, .rx_bit, .rx_valid, .rx_ready, .ref_active,
    .signal_present(sig_sync), .rx_overrun(ovr));
lpc_media_model MEDIA (.run, .present, .word(16'hb5a3), .clk_p(rc_p),
    .clk_n(rc_n), .data_p(rd_p), .data_n(rd_n), .sig_present(sig));
// ****
// tasks
// ****
task check(input logic [7:0] seen, input logic [7:0] exp, input string s);
    check_count = check_count + 1;
    if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("mismatch %s expected %h seen %h", s, exp, seen);
    end
endtask
task conclude;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
endtask
task reg_write(input logic [6:0] a, input logic [7:0] d);
    reg_cs <= 1'b1;
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_cs <= 1'b0;
    @(posedge sys_clk);
endtask
task reg_read(input logic [6:0] a);
    reg_cs <= 1'b1;
    reg_we <= 1'b0;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_cs <= 1'b0;
    @(posedge sys_clk);
    rd = reg_rdata;
endtask
// count tx clock rises, or valid rx cycles
task rises(input integer cyc, input logic use_rx);
    n = 0;
    lt = 1'b1;
    repeat (cyc) begin
        @(negedge sys_clk);
        if (use_rx ? rx_valid === 1'b1 : tc_p && !lt) n = n + 1;
        lt = tc_p;
    end
endtask
task tx_push(input logic b);
    tx_bit <= b;
    tx_valid <= 1'b1;
    @(negedge sys_clk);
    for (i = 0; i < 300 && tx_ready !== 1'b1; i = i + 1) @(negedge sys_clk);
    @(posedge sys_clk);
endtask
task rx_take(output logic b);
    @(negedge sys_clk);
    for (i = 0; i < 300 && rx_valid !== 1'b1; i = i + 1) @(negedge sys_clk);
    b = rx_bit;
    @(posedge sys_clk);
endtask
// ****
// tests
// ****
initial begin
    #100000;
    num_errors = num_errors + 1;
    conclude;
end
initial begin
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    reg_read(7'h01);
    check(rd, 8'h00, "config reset");
    reg_write(7'h01, 8'he7);
    reg_read(7'h01);
    check(rd, 8'he7, "config write");
    reg_write(7'h22, 8'h5a);
    reg_read(7'h22);
    check(rd, 8'h00, "unmapped read");
    reg_read(7'h01);
    check(rd, 8'he7, "config kept");
    run <= 1'b1;
    present <= 1'b1;
    // every source: synth 64 ns, link clocks 80 ns
    for (k = 0; k < 4; k = k + 1) begin
        reg_write(7'h01, {3'h0, k[1:0], 3'h0});
        repeat (300) @(posedge sys_clk);
        rises(80, 1'b0);
        // rise count in range for the selected source
        n = (n >= (k > 1 ? 7 : 9) && n <= (k > 1 ? 9 : 11));
        check(n[7:0], 8'h01, "rate");
    end
    ref_en = 1'b0;
    rx_ready <= 1'b1;
    repeat (200) @(posedge sys_clk);
    check(ref_active, 1'b0, "ref lost");
    rises(100, 1'b1);
    check(n[7:0], 8'h00, "rx without ref");
    reg_write(7'h01, 8'h00);
    rises(40, 1'b0);
    check(n[7:0], 8'h00, "synth without ref");
    ref_en = 1'b1;
    repeat (100) @(posedge sys_clk);
    check(ref_active, 1'b1, "ref back");
    txq.delete();
    tx_push(1'b1);
    tx_push(1'b1);
    tx_push(1'b0);
    tx_push(1'b1);
    tx_valid <= 1'b0;
    repeat (100) @(posedge sys_clk);
    for (k = 0; k < txq.size() && txq[k] !== 1'b1; k = k + 1);
    got[4:0] = {txq[k], txq[k+1], txq[k+2], txq[k+3], txq[k+4]};
    check({3'h0, got[4:0]}, 8'h1a, "tx");
    repeat (4) rx_take(got[0]);
    for (k = 31; k >= 0; k = k - 1) rx_take(got[k]);
    check(8'(got[31:16] === got[15:0]), 8'h01, "rx period");
    check(8'($countones(got[15:0])), 8'h09, "rx ones");
    present <= 1'b0;
    repeat (30) @(posedge sys_clk);
    rises(200, 1'b1);
    check(n[7:0], 8'h00, "rx absent");
    check(sig_sync, 1'b0, "present low");
    rx_ready <= 1'b0;
    present <= 1'b1;
    // count overrun pulses only in this stalled window
    n = 0;
    repeat (150) begin
        @(negedge sys_clk);
        if (ovr === 1'b1) n = n + 1;
    end
    check(8'(n >= 8), 8'h01, "overrun");
    check(rx_valid, 1'b1, "rx held");
    conclude;
end
endmodule
`default_nettype wire
